// *** puc_pkg.sv ***
// package for the pulse up/down counter: register map, field layout, reset values, timing
// assumes a single 25 MHz system clock and a plain single-cycle register port
package puc_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MENU_TIMEOUT_S = 60;
  localparam longint unsigned MENU_TIMEOUT_CYC_L = longint'(MENU_TIMEOUT_S) * longint'(CLK_HZ);
  localparam int unsigned MENU_TIMEOUT_CYC = int'(MENU_TIMEOUT_CYC_L);

  localparam int AW = 4;
  localparam int DW = 16;
  localparam int CW = 16;
  localparam int DIVW = 10;
  localparam int LIMW = 14;
  localparam int ADRW = 8;

  localparam logic [AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AW-1:0] REG_DIV = 4'h1;
  localparam logic [AW-1:0] REG_UPPER = 4'h2;
  localparam logic [AW-1:0] REG_ADDR = 4'h3;
  localparam logic [AW-1:0] REG_SERVAL = 4'h4;
  localparam logic [AW-1:0] REG_SWPT = 4'h5;
  localparam logic [AW-1:0] REG_COUNT = 4'h6;
  localparam logic [AW-1:0] REG_STATUS = 4'h7;

  // CTRL layout
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EDGE_BIT = 2;
  localparam int CTRL_POL_LSB = 3;

  localparam logic [DIVW-1:0] DIV_MIN = 10'h001;
  localparam logic [DIVW-1:0] DIV_MAX = 10'h3E8;
  localparam logic [LIMW-1:0] UPPER_MAX = 14'h270F;
  localparam logic [ADRW-1:0] ADDR_MAX = 8'hEF;
  localparam logic signed [CW-1:0] ABS_MAX = 16'sh270F;
  localparam logic signed [CW-1:0] ABS_MIN = -16'sh07CF;
  localparam logic signed [CW-1:0] CNT_ZERO = 16'sh0000;

  localparam logic [DIVW-1:0] DIV_RST = 10'h001;
  localparam logic [LIMW-1:0] UPPER_RST = 14'h270F;
  localparam logic [DW-1:0] SWPT_RST = 16'h0000;

  typedef enum logic [1:0] {
    MODE_UP,
    MODE_DOWN,
    MODE_SERIAL
  } puc_mode_t;

  typedef enum logic [1:0] {
    POL_OFF,
    POL_ERR,
    POL_CLAMP
  } puc_policy_t;

  typedef struct packed {
    puc_mode_t mode;
    logic falling_edge_setting;
    puc_policy_t policy;
    logic [DIVW-1:0] div;
    logic [LIMW-1:0] upper;
  } puc_cfg_t;

  localparam puc_cfg_t CFG_RST = '{mode: MODE_UP, falling_edge_setting: 1'b0,
                                   policy: POL_OFF, div: DIV_RST, upper: UPPER_RST};

  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } puc_bus_req_t;

  typedef struct packed {
    logic switch_on;
    logic menu_open;
    logic below;
    logic above;
    logic err;
  } puc_status_t;
endpackage : puc_pkg

// *** puc_prescale.sv ***
// prescaler: passes one tick for every div qualified input events
// assumes evt is a one-cycle pulse synchronous to sys_clk and div already range checked
`timescale 1ns/1ps
module puc_prescale
  import puc_pkg::*;
#(
  parameter int DIV_W = DIVW
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic evt,
  input wire logic [DIV_W-1:0] div,
  output logic tick
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_inc;
  logic wrap;

  assign cnt_inc = cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
  // div of zero behaves as one so a bad value cannot stop counting
  assign wrap = (cnt_inc >= div);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (clr) begin
      cnt_q <= '0;
    end else if (evt) begin
      cnt_q <= wrap ? '0 : cnt_inc; // RL7
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick <= 1'b0;
    end else begin
      tick <= evt & wrap & ~clr; // RL7
    end
  end

  property p_tick_needs_evt;
    @(posedge sys_clk) disable iff (!rstn)
    tick |-> $past(evt);
  endproperty
  a_tick_needs_evt: assert property (p_tick_needs_evt) else $error("tick without event"); // RL7

  // a clear must also swallow the tick of a wrap in the same cycle
  property p_clr_quiet;
    @(posedge sys_clk) disable iff (!rstn)
    clr |=> (cnt_q == '0) && !tick;
  endproperty
  a_clr_quiet: assert property (p_clr_quiet) else $error("prescaler not cleared"); // RL7
endmodule : puc_prescale

// *** puc_counter.sv ***
// pulse up/down counter top: edge select, prescaler, limits, reset contact, retention,
// serial display mode, configuration menu with commit and timeout, register port
// assumes all inputs synchronous to sys_clk; nonvolatile store answers nv_rd_data at once
//
// Notes on behaviour
// RL1: up-count mode starts at zero and counts up on each qualified pulse.
// RL2: down-count mode starts at the upper limit and counts down.
// RL3: while the reset contact is grounded the count is held at zero.
// RL4: releasing the contact restarts from the mode's start value.
// RL5: count is mirrored to nonvolatile storage and restored after power-up.
// RL6: edge setting picks rising or falling input edges as count events.
// RL7: a prescaler divides events by 1 to 1000 before counting.
// RL8: upper counting limit is configurable from 0 to 9999.
// RL9: lower counting limit is fixed at zero.
// RL10: with policy off the count runs on until the absolute range ends.
// RL11: with error policy an error flags whenever count leaves 0..upper.
// RL12: with clamp policy the display shows upper or zero outside the range.
// RL13: serial-display mode makes no local count.
// RL14: serial-display mode shows the value written by the remote party.
// RL15: switching output keeps working on the displayed value.
// RL16: bus address is settable from 0 to 239.
// RL17: a bus-wide system initialisation resets the bus address.
// RL18: stepping past the last menu item stores settings and resets.
// RL19: more than 60 s without a key closes the menu.
// RL20: each prescaler tick moves the count by exactly one.
`timescale 1ns/1ps
module puc_counter
  import puc_pkg::*;
#(
  parameter int unsigned MENU_TIMEOUT = MENU_TIMEOUT_CYC,
  parameter int MENU_ITEMS = 6,
  parameter logic [ADRW-1:0] ADDR_DEFAULT = 8'h01
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire puc_bus_req_t bus_req,
  output logic [DW-1:0] bus_rdata,
  input wire logic pulse_in,
  input wire logic count_reset_n,
  input wire logic param_key,
  input wire logic adjust_key,
  input wire logic sys_init,
  input wire logic [CW-1:0] nv_rd_data,
  output logic nv_wr,
  output logic [CW-1:0] nv_wr_data,
  output logic [DW-1:0] disp_value,
  output logic err_out,
  output logic switch_out,
  output logic [ADRW-1:0] bus_address,
  output logic settings_store
);
  typedef enum logic {
    MENU_CLOSED,
    MENU_OPEN
  } puc_menu_t;

  puc_cfg_t cfg_q;
  puc_cfg_t cfg_sh_q;
  puc_menu_t menu_q;
  logic [7:0] item_q;
  logic [31:0] idle_q;
  logic restore_q;
  logic soft_rst;
  logic timeout;
  logic key;
  logic in_prev_q;
  logic cont_prev_q;
  logic evt;
  logic tick;
  logic release_evt;
  logic signed [CW-1:0] count_q;
  logic signed [CW-1:0] count_d;
  logic signed [CW-1:0] start_val;
  logic signed [CW-1:0] upper_s;
  logic [DW-1:0] serval_q;
  logic [DW-1:0] swpt_q;
  logic [ADRW-1:0] addr_q;
  logic above;
  logic below;
  logic err_d;
  logic [DW-1:0] disp_d;
  logic cfg_wr;
  puc_status_t status;

  // ---------------- configuration menu
  assign cfg_wr = bus_req.wr && (menu_q == MENU_OPEN) &&
    ((bus_req.addr == REG_CTRL) || (bus_req.addr == REG_DIV) || (bus_req.addr == REG_UPPER));
  assign key = param_key | adjust_key | cfg_wr;
  assign timeout = (menu_q == MENU_OPEN) && (idle_q >= MENU_TIMEOUT - 32'd1) && !key;
  assign soft_rst = (menu_q == MENU_OPEN) && param_key &&
    (item_q == 8'(MENU_ITEMS - 1));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      menu_q <= MENU_CLOSED;
      item_q <= '0;
    end else begin
      case (menu_q)
        MENU_CLOSED: begin
          if (param_key) begin
            menu_q <= MENU_OPEN;
            item_q <= '0;
          end
        end
        MENU_OPEN: begin
          if (soft_rst) begin
            menu_q <= MENU_CLOSED; // RL18
          end else if (timeout) begin
            menu_q <= MENU_CLOSED; // RL19
          end else if (param_key) begin
            item_q <= item_q + 8'h01;
          end
        end
        default: menu_q <= MENU_CLOSED;
      endcase
    end
  end

  // idle counter only runs while the menu is open
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      idle_q <= '0;
    end else if (menu_q != MENU_OPEN || key) begin
      idle_q <= '0;
    end else begin
      idle_q <= idle_q + 32'd1; // RL19
    end
  end

  // shadow settings take effect only when the menu is stepped to its end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_sh_q <= CFG_RST;
    end else if (timeout) begin
      cfg_sh_q <= cfg_q; // RL19
    end else if (cfg_wr) begin
      case (bus_req.addr)
        REG_CTRL: begin
          if (bus_req.wdata[CTRL_MODE_LSB +: 2] <= 2'(MODE_SERIAL)) begin
            cfg_sh_q.mode <= puc_mode_t'(bus_req.wdata[CTRL_MODE_LSB +: 2]);
          end
          cfg_sh_q.falling_edge_setting <= bus_req.wdata[CTRL_EDGE_BIT]; // RL6
          if (bus_req.wdata[CTRL_POL_LSB +: 2] <= 2'(POL_CLAMP)) begin
            cfg_sh_q.policy <= puc_policy_t'(bus_req.wdata[CTRL_POL_LSB +: 2]);
          end
        end
        REG_DIV: begin
          if (bus_req.wdata[DIVW-1:0] >= DIV_MIN && bus_req.wdata[DIVW-1:0] <= DIV_MAX &&
              bus_req.wdata[DW-1:DIVW] == '0) begin
            cfg_sh_q.div <= bus_req.wdata[DIVW-1:0]; // RL7
          end
        end
        REG_UPPER: begin
          if (bus_req.wdata[LIMW-1:0] <= UPPER_MAX && bus_req.wdata[DW-1:LIMW] == '0) begin
            cfg_sh_q.upper <= bus_req.wdata[LIMW-1:0]; // RL8
          end
        end
        default: cfg_sh_q <= cfg_sh_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= CFG_RST;
    end else if (soft_rst) begin
      cfg_q <= cfg_sh_q; // RL18
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      settings_store <= 1'b0;
    end else begin
      settings_store <= soft_rst; // RL18
    end
  end

  // ---------------- bus address and serial value
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= ADDR_DEFAULT;
    end else if (sys_init) begin
      addr_q <= ADDR_DEFAULT; // RL17
    end else if (bus_req.wr && bus_req.addr == REG_ADDR &&
                 bus_req.wdata[ADRW-1:0] <= ADDR_MAX && bus_req.wdata[DW-1:ADRW] == '0) begin
      addr_q <= bus_req.wdata[ADRW-1:0]; // RL16
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      serval_q <= '0;
      swpt_q <= SWPT_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == REG_SERVAL) begin
        serval_q <= bus_req.wdata; // RL14
      end
      if (bus_req.addr == REG_SWPT) begin
        swpt_q <= bus_req.wdata;
      end
    end
  end

  // ---------------- input edges and prescaler
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      in_prev_q <= 1'b0;
      cont_prev_q <= 1'b1;
    end else begin
      in_prev_q <= pulse_in;
      cont_prev_q <= count_reset_n;
    end
  end

  assign release_evt = count_reset_n & ~cont_prev_q;
  // no events reach the prescaler in serial mode or while the contact is grounded
  assign evt = (cfg_q.mode != MODE_SERIAL) && count_reset_n && !restore_q && // RL13
    (cfg_q.falling_edge_setting ? (in_prev_q & ~pulse_in) : (pulse_in & ~in_prev_q)); // RL6

  puc_prescale #(
    .DIV_W(DIVW)
  ) u_prescale (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clr(~count_reset_n | soft_rst),
    .evt(evt),
    .div(cfg_q.div),
    .tick(tick)
  );

  // ---------------- count
  assign upper_s = signed'({{(CW-LIMW){1'b0}}, cfg_q.upper});
  assign start_val = (cfg_q.mode == MODE_DOWN) ? upper_s : CNT_ZERO; // RL1 RL2

  // restore is raised by reset and by the menu reset, so nv data is caught after release
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      restore_q <= 1'b1;
    end else begin
      restore_q <= soft_rst;
    end
  end

  always_comb begin
    count_d = count_q;
    if (restore_q) begin
      count_d = signed'(nv_rd_data); // RL5
    end else if (!count_reset_n) begin
      count_d = CNT_ZERO; // RL3
    end else if (release_evt) begin
      count_d = start_val; // RL4
    end else if (tick && cfg_q.mode == MODE_UP && count_q < ABS_MAX) begin
      count_d = count_q + 16'sh0001; // RL20 RL10
    end else if (tick && cfg_q.mode == MODE_DOWN && count_q > ABS_MIN) begin
      count_d = count_q - 16'sh0001; // RL20 RL10
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= CNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  // every change is written through; the store sees the new value with the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      nv_wr <= 1'b0;
      nv_wr_data <= '0;
    end else begin
      nv_wr <= (count_d != count_q) && !restore_q; // RL5
      nv_wr_data <= count_d;
    end
  end

  // ---------------- limits and display
  assign above = count_q > upper_s;
  assign below = count_q < CNT_ZERO; // RL9

  always_comb begin
    disp_d = count_q;
    err_d = 1'b0;
    if (cfg_q.mode == MODE_SERIAL) begin
      disp_d = serval_q; // RL14
    end else begin
      case (cfg_q.policy)
        POL_ERR: err_d = above | below; // RL11
        POL_CLAMP: begin
          if (above) begin
            disp_d = upper_s; // RL12
          end else if (below) begin
            disp_d = CNT_ZERO; // RL12
          end
        end
        default: err_d = (count_q >= ABS_MAX) || (count_q <= ABS_MIN); // RL10
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      disp_value <= '0;
      err_out <= 1'b0;
      switch_out <= 1'b0;
    end else begin
      disp_value <= disp_d;
      err_out <= err_d;
      switch_out <= signed'(disp_d) >= signed'(swpt_q); // RL15
    end
  end

  assign bus_address = addr_q;

  // ---------------- register read port
  assign status = '{switch_on: switch_out, menu_open: (menu_q == MENU_OPEN),
                    below: below, above: above, err: err_out};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata <= '0;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        REG_CTRL: bus_rdata <= DW'({cfg_sh_q.policy, cfg_sh_q.falling_edge_setting,
                                    cfg_sh_q.mode});
        REG_DIV: bus_rdata <= DW'(cfg_sh_q.div);
        REG_UPPER: bus_rdata <= DW'(cfg_sh_q.upper);
        REG_ADDR: bus_rdata <= DW'(addr_q);
        REG_SERVAL: bus_rdata <= serval_q;
        REG_SWPT: bus_rdata <= swpt_q;
        REG_COUNT: bus_rdata <= count_q;
        REG_STATUS: bus_rdata <= DW'(status);
        default: bus_rdata <= '0;
      endcase
    end else begin
      bus_rdata <= '0;
    end
  end

  // ---------------- assertions
  property p_contact_clears;
    @(posedge sys_clk) disable iff (!rstn)
    (!count_reset_n && !restore_q) |=> (count_q == CNT_ZERO);
  endproperty
  a_contact_clears: assert property (p_contact_clears) else $error("count not cleared"); // RL3

  property p_release_start;
    @(posedge sys_clk) disable iff (!rstn)
    (release_evt && !restore_q) |=> (count_q == $past(start_val));
  endproperty
  a_release_start: assert property (p_release_start) else $error("bad restart value"); // RL4

  property p_up_step;
    @(posedge sys_clk) disable iff (!rstn)
    (tick && count_reset_n && !release_evt && !restore_q && cfg_q.mode == MODE_UP &&
     count_q < ABS_MAX) |=> (count_q == $past(count_q) + 16'sh0001);
  endproperty
  a_up_step: assert property (p_up_step) else $error("up step not one"); // RL20

  property p_down_step;
    @(posedge sys_clk) disable iff (!rstn)
    (tick && count_reset_n && !release_evt && !restore_q && cfg_q.mode == MODE_DOWN &&
     count_q > ABS_MIN) |=> (count_q == $past(count_q) - 16'sh0001);
  endproperty
  a_down_step: assert property (p_down_step) else $error("down step not one"); // RL20

  property p_no_local_count;
    @(posedge sys_clk) disable iff (!rstn)
    (cfg_q.mode == MODE_SERIAL) |-> !evt;
  endproperty
  a_no_local_count: assert property (p_no_local_count) else $error("serial mode counted"); // RL13

  property p_serial_disp;
    @(posedge sys_clk) disable iff (!rstn)
    (cfg_q.mode == MODE_SERIAL) ##1 (cfg_q.mode == MODE_SERIAL) |-> disp_value == $past(serval_q);
  endproperty
  a_serial_disp: assert property (p_serial_disp) else $error("serial value not shown"); // RL14

  property p_clamp_high;
    @(posedge sys_clk) disable iff (!rstn)
    (cfg_q.mode != MODE_SERIAL && cfg_q.policy == POL_CLAMP && above) |=>
      (disp_value == $past(upper_s));
  endproperty
  a_clamp_high: assert property (p_clamp_high) else $error("clamp not applied"); // RL12

  property p_err_flag;
    @(posedge sys_clk) disable iff (!rstn)
    (cfg_q.mode != MODE_SERIAL && cfg_q.policy == POL_ERR) |=> (err_out == $past(above | below));
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag wrong"); // RL11

  property p_addr_range;
    @(posedge sys_clk) disable iff (!rstn)
    bus_address <= ADDR_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("address out of range"); // RL16

  property p_init_addr;
    @(posedge sys_clk) disable iff (!rstn)
    sys_init |=> (bus_address == ADDR_DEFAULT);
  endproperty
  a_init_addr: assert property (p_init_addr) else $error("address not reset"); // RL17

  property p_commit;
    @(posedge sys_clk) disable iff (!rstn)
    soft_rst |=> (cfg_q == $past(cfg_sh_q)) && settings_store && restore_q &&
      (menu_q == MENU_CLOSED);
  endproperty
  a_commit: assert property (p_commit) else $error("menu end did not store"); // RL18

  property p_timeout;
    @(posedge sys_clk) disable iff (!rstn)
    timeout |=> (menu_q == MENU_CLOSED) && (cfg_sh_q == $past(cfg_q));
  endproperty
  a_timeout: assert property (p_timeout) else $error("menu not closed on timeout"); // RL19

  property p_div_range;
    @(posedge sys_clk) disable iff (!rstn)
    (cfg_q.div >= DIV_MIN) && (cfg_q.div <= DIV_MAX) && (cfg_q.upper <= UPPER_MAX);
  endproperty
  a_div_range: assert property (p_div_range) else $error("config out of range"); // RL7

  c_up_count: cover property (@(posedge sys_clk) disable iff (!rstn)
    tick && cfg_q.mode == MODE_UP ##1 count_q > CNT_ZERO);
  c_contact: cover property (@(posedge sys_clk) disable iff (!rstn) release_evt);
  c_commit: cover property (@(posedge sys_clk) disable iff (!rstn) soft_rst);
  c_clamp: cover property (@(posedge sys_clk) disable iff (!rstn)
    cfg_q.policy == POL_CLAMP && above);
endmodule : puc_counter

// *** puc_pulse_src.sv ***
// pulse transmitter model with a ttl output, idle low
// assumes the counter samples the line on sys_clk; spans are in clock cycles
`timescale 1ns/1ps
module puc_pulse_src (
  input wire logic sys_clk,
  output logic pulse_out
);
  initial pulse_out = 1'b0;
  // a level is never shorter than one cycle, so no edge can be lost
  task automatic level(input logic v, input int span);
    @(posedge sys_clk);
    pulse_out <= v;
    repeat (span - 1) @(posedge sys_clk);
  endtask : level
  // span 1 is the fastest legal source, longer spans a slow one
  task automatic send(input int n, input int span);
    for (int i = 0; i < n; i++) begin
      level(1'b1, span);
      level(1'b0, span);
    end
  endtask : send
endmodule : puc_pulse_src

// *** tb_pulse_up_down_counter.sv ***
// testbench for the pulse counter: bus tasks, nonvolatile store, scenarios
// assumes puc_pkg and puc_counter compiled first; menu timeout cut to 50 cycles
`timescale 1ns/1ps
module tb_pulse_up_down_counter;
  import puc_pkg::*;
  localparam int unsigned TMO = 50;
  logic sys_clk;
  logic rstn;
  puc_bus_req_t bus_req;
  logic [DW-1:0] bus_rdata;
  logic pulse_in;
  logic count_reset_n;
  logic param_key;
  logic adjust_key;
  logic sys_init;
  logic [CW-1:0] nv_q;
  logic nv_wr;
  logic [CW-1:0] nv_wr_data;
  logic [DW-1:0] disp_value;
  logic err_out;
  logic switch_out;
  logic [ADRW-1:0] bus_address;
  logic settings_store;
  logic [DW-1:0] rv;
  int n_fail;
  int checked;

  puc_counter #(.MENU_TIMEOUT(TMO)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pulse_in(pulse_in), .count_reset_n(count_reset_n), .param_key(param_key),
    .adjust_key(adjust_key), .sys_init(sys_init), .nv_rd_data(nv_q), .nv_wr(nv_wr),
    .nv_wr_data(nv_wr_data), .disp_value(disp_value), .err_out(err_out),
    .switch_out(switch_out), .bus_address(bus_address),
    .settings_store(settings_store));
  puc_pulse_src src (.sys_clk(sys_clk), .pulse_out(pulse_in));

  // store survives rstn, which stands in for a supply loss
  always @(posedge sys_clk) begin
    if (nv_wr === 1'b1) nv_q <= nv_wr_data;
  end

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // ends 1 ns past the edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a);
    @(posedge sys_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 rv = bus_rdata;
  endtask : rd

  task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    rd(a);
    chk(rv, exp);
  endtask : rdc

  task automatic key();
    @(posedge sys_clk);
    param_key <= 1'b1;
    @(posedge sys_clk);
    param_key <= 1'b0;
  endtask : key

  // open, write settings, then six presses walk past the last item
  task automatic cfg(input logic [15:0] c, input logic [15:0] dv, input logic [15:0] up);
    int i;
    key();
    wr(REG_CTRL, c);
    wr(REG_DIV, dv);
    wr(REG_UPPER, up);
    repeat (6) key();
    #1;
    for (i = 0; i < 5 && settings_store !== 1'b1; i++) cyc(1);
    chk({15'h0000, settings_store}, 16'h0001);
    if (settings_store !== 1'b1) stop_test();
    cyc(3);
  endtask : cfg

  task automatic contact();
    @(posedge sys_clk);
    count_reset_n <= 1'b0;
    src.send(2, 1);
    rdc(REG_COUNT, 16'h0000);
    @(posedge sys_clk);
    count_reset_n <= 1'b1;
    cyc(3);
  endtask : contact

  task automatic pulses(input int n, input int span);
    src.send(n, span);
    cyc(4);
  endtask : pulses

  task automatic t_start();
    chk(disp_value, 16'h0000);
    chk({8'h00, bus_address}, 16'h0001);
    rdc(REG_COUNT, 16'h0000);
  endtask : t_start

  task automatic t_up();
    pulses(3, 1);
    rdc(REG_COUNT, 16'h0003);
    chk(disp_value, 16'h0003);
    chk(nv_q, 16'h0003);
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    cyc(2);
    rdc(REG_COUNT, 16'h0003);
  endtask : t_up

  task automatic t_div();
    cfg(16'h0000, 16'h0003, 16'h270F);
    wr(REG_DIV, 16'h0005);
    rdc(REG_DIV, 16'h0003);
    pulses(6, 5);
    rdc(REG_COUNT, 16'h0005);
  endtask : t_div

  // a rising edge alone must not count once falling is selected
  task automatic t_edge();
    cfg(16'h0004, 16'h0001, 16'h0002);
    src.level(1'b1, 3);
    rdc(REG_COUNT, 16'h0005);
    src.level(1'b0, 1);
    cyc(4);
    rdc(REG_COUNT, 16'h0006);
    chk(disp_value, 16'h0006);
    chk({15'h0000, err_out}, 16'h0000);
  endtask : t_edge

  task automatic t_down();
    cfg(16'h0009, 16'h0001, 16'h0002);
    chk({15'h0000, err_out}, 16'h0001);
    contact();
    rdc(REG_COUNT, 16'h0002);
    chk({15'h0000, err_out}, 16'h0000);
    pulses(3, 1);
    rdc(REG_COUNT, 16'hFFFF);
    chk({15'h0000, err_out}, 16'h0001);
  endtask : t_down

  task automatic t_clamp();
    cfg(16'h0011, 16'h0001, 16'h0002);
    contact();
    pulses(3, 1);
    chk(disp_value, 16'h0000);
    cfg(16'h0010, 16'h0001, 16'h0002);
    contact();
    pulses(3, 1);
    chk(disp_value, 16'h0002);
  endtask : t_clamp

  task automatic t_serial();
    cfg(16'h0002, 16'h0001, 16'h270F);
    wr(REG_SERVAL, 16'h1234);
    cyc(1);
    chk(disp_value, 16'h1234);
    wr(REG_SWPT, 16'h1000);
    cyc(2);
    chk({15'h0000, switch_out}, 16'h0001);
    wr(REG_SWPT, 16'h2000);
    cyc(2);
    chk({15'h0000, switch_out}, 16'h0000);
    pulses(2, 1);
    rdc(REG_COUNT, 16'h0003);
  endtask : t_serial

  task automatic t_addr();
    wr(REG_ADDR, 16'h00EF);
    cyc(1);
    chk({8'h00, bus_address}, 16'h00EF);
    wr(REG_ADDR, 16'h00F0);
    cyc(1);
    chk({8'h00, bus_address}, 16'h00EF);
    @(posedge sys_clk);
    sys_init <= 1'b1;
    @(posedge sys_clk);
    sys_init <= 1'b0;
    cyc(1);
    chk({8'h00, bus_address}, 16'h0001);
  endtask : t_addr

  // the value button alone must restart the idle count
  task automatic t_menu();
    key();
    cyc(30);
    rd(REG_STATUS);
    chk({15'h0000, rv[3]}, 16'h0001);
    @(posedge sys_clk);
    adjust_key <= 1'b1;
    @(posedge sys_clk);
    adjust_key <= 1'b0;
    cyc(30);
    rd(REG_STATUS);
    chk({15'h0000, rv[3]}, 16'h0001);
    cyc(30);
    rd(REG_STATUS);
    chk({15'h0000, rv[3]}, 16'h0000);
  endtask : t_menu

  initial begin
    rstn = 1'b0;
    bus_req = '0;
    count_reset_n = 1'b1;
    param_key = 1'b0;
    adjust_key = 1'b0;
    sys_init = 1'b0;
    nv_q = 16'h0000;
    n_fail = 0;
    checked = 0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    cyc(2);
    t_start();
    t_up();
    t_div();
    t_edge();
    t_down();
    t_clamp();
    t_serial();
    t_addr();
    t_menu();
    stop_test();
  end
endmodule : tb_pulse_up_down_counter
